//--- include/ddr_pm_pkg.sv
// shared constants, pin carrier and state encoding for the refresh/power controller
// assumes one 20 MHz clock that also clocks the memory command pins
// Notes on behaviour
// - refresh: cs, ras, cas low, we high, cke high
// - refresh only after all banks precharged, precharge_time met
// - only nop/deselect for refresh_cycle_time after refresh
// - at most eight refreshes postponed, gap nine intervals
// - more than eight advanced refreshes earn nothing
// - all postponed refreshes done before self-refresh entry
// - self-refresh entry is refresh code with cke low
// - banks precharged, termination off before self-refresh entry
// - cke held low throughout self-refresh
// - stay in self-refresh at least min_cke_pulse
// - clock stops after stop delay, restarts before exit
// - exit: cke high with nop, then exit delays
// - nop, cke high, termination off during exit delay
// - one extra refresh before self-refresh re-entry
// - power-down: cke low with nop, never mid-operation
// - nop/deselect throughout cke blanking period
// - slow exit needs dll delay, fast exit not
// - cke pulses min width, power-down under nine intervals; code leaves power-down only at eight owed, so longer after advanced refreshes
package ddr_pm_pkg;
    localparam int CLK_PERIOD_PS = 50000;

    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;

    localparam int CTRL_SR_BIT     = 0;
    localparam int CTRL_PD_BIT     = 1;
    localparam int CTRL_FASTPD_BIT = 2;
    localparam int CTRL_REFNOW_BIT = 3;
    localparam int CTRL_DRST_BIT   = 4;

    localparam logic signed [4:0] OWED_MAX = 5'sh08;
    localparam logic signed [4:0] OWED_MIN = -5'sh08;

    typedef enum logic [3:0] {
        ST_IDLE       = 4'h0,
        ST_PRE_W      = 4'h1,
        ST_REF_W      = 4'h3,
        ST_PD_ENT     = 4'h2,
        ST_PD         = 4'h6,
        ST_PD_EXIT    = 4'h7,
        ST_SR_ENT     = 4'h5,
        ST_SR         = 4'h4,
        ST_SR_RESTART = 4'hC,
        ST_SR_EXIT    = 4'hD
    } state_type;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_type;

    localparam cmd_type CMD_NOP = 4'h7;
    localparam cmd_type CMD_DES = 4'hF;
    localparam cmd_type CMD_REF = 4'h1;
    localparam cmd_type CMD_PRE = 4'h2;

    typedef struct packed {
        cmd_type cmd;
        logic    cke;
        logic    termination_pin;
        logic    a10;
        logic    ck_en;
        logic    reset_n;
    } ddr_pins_type;

    // deselect, cke high, termination off, clock running, memory out of reset
    localparam ddr_pins_type PINS_RESET = 9'h1F3;

    // least times round up, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_floor(input int ns);
        int c;
        c = (ns * 1000) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction
endpackage

//--- logic/ddr_pm_ctrl.sv
// refresh, self-refresh and power-down sequencer driving a ddr3 command port
// assumes all banks are closed by this block; no read/write traffic shares the pins
//
// The register addresses and register access over Wishbone were left to the implementer.
module ddr_pm_ctrl #(
    parameter int AVG_REFRESH_INTERVAL_NS     = 7800,
    parameter int REFRESH_CYCLE_TIME_NS      = 160,
    parameter int TRP_NS       = 14,
    parameter int MIN_CKE_PULSE_NS      = 5,
    parameter int CLOCK_STOP_DELAY_NS    = 10,
    parameter int CLOCK_RESTART_DELAY_NS    = 10,
    parameter int CKE_BLANKING_PERIOD_CK    = 1,
    parameter int TXP_NS       = 6,
    parameter int POWERDOWN_EXIT_DLL_DELAY_NS    = 24,
    parameter int SELFREFRESH_EXIT_DLL_DELAY_CK    = 512
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output ddr_pm_pkg::ddr_pins_type     ddr_o
);
    localparam int AVG_REFRESH_INTERVAL_CYC  = ddr_pm_pkg::cyc_floor(AVG_REFRESH_INTERVAL_NS);
    localparam int REFRESH_CYCLE_TIME_CYC   = ddr_pm_pkg::cyc_ceil(REFRESH_CYCLE_TIME_NS);
    localparam int TRP_CYC    = ddr_pm_pkg::cyc_ceil(TRP_NS);
    localparam int MIN_CKE_PULSE_CYC   = ddr_pm_pkg::cyc_ceil(MIN_CKE_PULSE_NS);
    localparam int SRENT_CYC  = ddr_pm_pkg::imax(MIN_CKE_PULSE_CYC, ddr_pm_pkg::cyc_ceil(CLOCK_STOP_DELAY_NS));
    localparam int CLOCK_RESTART_DELAY_CYC = ddr_pm_pkg::cyc_ceil(CLOCK_RESTART_DELAY_NS);
    localparam int PDENT_CYC  = ddr_pm_pkg::imax(CKE_BLANKING_PERIOD_CK, MIN_CKE_PULSE_CYC);
    localparam int PDXF_CYC   = ddr_pm_pkg::imax(MIN_CKE_PULSE_CYC, ddr_pm_pkg::cyc_ceil(TXP_NS));
    localparam int PDXS_CYC   = ddr_pm_pkg::imax(MIN_CKE_PULSE_CYC, ddr_pm_pkg::cyc_ceil(POWERDOWN_EXIT_DLL_DELAY_NS));

    typedef struct packed {
        ddr_pm_pkg::state_type    st;
        logic                     tgt_sr;
        logic [9:0]               wcnt;
        logic [11:0]              tick;
        logic signed [4:0]        owed;
        logic                     need_extra;
        logic                     ref_pend;
        logic                     sr_req;
        logic                     pd_req;
        logic                     fast_pd;
        logic                     dram_rst;
        ddr_pm_pkg::ddr_pins_type pins;
        logic                     ack;
        logic [31:0]              rdat;
    } ctl_type;

    ctl_type s_r;
    ctl_type s_nxt;
    logic    ref_issued;
    logic    tick_ev;
    logic    want_ref;

    always_comb begin
        s_nxt      = s_r;
        ref_issued = 1'b0;
        tick_ev    = 1'b0;
        want_ref   = 1'b0;
        s_nxt.ack  = 1'b0;
        s_nxt.pins.cmd = ddr_pm_pkg::CMD_DES;
        s_nxt.pins.a10 = 1'b0;
        // termination never used by this block, so it is always off for entries
        s_nxt.pins.termination_pin = 1'b0;
        s_nxt.pins.reset_n = !s_r.dram_rst;
        if (s_r.wcnt != 10'h000) begin
            s_nxt.wcnt = s_r.wcnt - 10'h001;
        end

        // interval timer is cleared and held at zero in self-refresh: the device refreshes itself there
        if (s_r.st == ddr_pm_pkg::ST_SR_ENT || s_r.st == ddr_pm_pkg::ST_SR ||
            s_r.st == ddr_pm_pkg::ST_SR_RESTART) begin
            s_nxt.tick = 12'h000;
        end else if (s_r.tick == 12'(AVG_REFRESH_INTERVAL_CYC - 1)) begin
            s_nxt.tick = 12'h000;
            tick_ev    = 1'b1;
        end else begin
            s_nxt.tick = s_r.tick + 12'h001;
        end

        want_ref = (s_r.owed > 5'sh00 && (!s_r.pd_req || s_r.owed == ddr_pm_pkg::OWED_MAX))
                   || s_r.ref_pend || (s_r.sr_req && s_r.need_extra);

        case (s_r.st)
            ddr_pm_pkg::ST_IDLE: begin
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                s_nxt.pins.cke = 1'b1;
                if (want_ref || (s_r.sr_req && s_r.owed <= 5'sh00)) begin
                    // precharge-all first, so every bank is idle for the wait
                    s_nxt.pins.cmd = ddr_pm_pkg::CMD_PRE;
                    s_nxt.pins.a10 = 1'b1;
                    s_nxt.tgt_sr   = !want_ref;
                    s_nxt.wcnt     = 10'(TRP_CYC - 1);
                    s_nxt.st       = ddr_pm_pkg::ST_PRE_W;
                end else if (s_r.pd_req) begin
                    s_nxt.pins.cke = 1'b0;
                    s_nxt.wcnt     = 10'(PDENT_CYC - 1);
                    s_nxt.st       = ddr_pm_pkg::ST_PD_ENT;
                end
            end
            ddr_pm_pkg::ST_PRE_W: begin
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.pins.cmd = ddr_pm_pkg::CMD_REF;
                    // a tick landing now makes this a plain refresh, entry retried after
                    if (s_r.tgt_sr && s_r.owed <= 5'sh00 && !tick_ev) begin
                        s_nxt.pins.cke = 1'b0;
                        s_nxt.wcnt     = 10'(SRENT_CYC - 1);
                        s_nxt.st       = ddr_pm_pkg::ST_SR_ENT;
                    end else begin
                        ref_issued       = 1'b1;
                        s_nxt.need_extra = 1'b0;
                        s_nxt.wcnt       = 10'(REFRESH_CYCLE_TIME_CYC - 1);
                        s_nxt.st         = ddr_pm_pkg::ST_REF_W;
                    end
                end
            end
            ddr_pm_pkg::ST_REF_W: begin
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.st = ddr_pm_pkg::ST_IDLE;
                end
            end
            ddr_pm_pkg::ST_SR_ENT: begin
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.pins.ck_en = 1'b0;
                    s_nxt.st         = ddr_pm_pkg::ST_SR;
                end
            end
            ddr_pm_pkg::ST_SR: begin
                if (!s_r.sr_req) begin
                    s_nxt.pins.ck_en = 1'b1;
                    s_nxt.wcnt       = 10'(CLOCK_RESTART_DELAY_CYC - 1);
                    s_nxt.st         = ddr_pm_pkg::ST_SR_RESTART;
                end
            end
            ddr_pm_pkg::ST_SR_RESTART: begin
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.pins.cmd   = ddr_pm_pkg::CMD_NOP;
                    s_nxt.pins.cke   = 1'b1;
                    s_nxt.need_extra = 1'b1;
                    s_nxt.wcnt       = 10'(SELFREFRESH_EXIT_DLL_DELAY_CK - 1);
                    s_nxt.st         = ddr_pm_pkg::ST_SR_EXIT;
                end
            end
            ddr_pm_pkg::ST_SR_EXIT: begin
                // longest exit delay covers the shorter one as well
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.st = ddr_pm_pkg::ST_IDLE;
                end
            end
            ddr_pm_pkg::ST_PD_ENT: begin
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.st = ddr_pm_pkg::ST_PD;
                end
            end
            ddr_pm_pkg::ST_PD: begin
                if (!s_r.pd_req || s_r.owed == ddr_pm_pkg::OWED_MAX) begin
                    s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                    s_nxt.pins.cke = 1'b1;
                    s_nxt.wcnt     = s_r.fast_pd ? 10'(PDXF_CYC - 1)
                                                 : 10'(PDXS_CYC - 1);
                    s_nxt.st       = ddr_pm_pkg::ST_PD_EXIT;
                end
            end
            ddr_pm_pkg::ST_PD_EXIT: begin
                s_nxt.pins.cmd = ddr_pm_pkg::CMD_NOP;
                if (s_r.wcnt == 10'h000) begin
                    s_nxt.st = ddr_pm_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ddr_pm_pkg::ST_IDLE;
            end
        endcase

        // owed count: ticks add, refreshes pay back, clamped both ways
        if (s_r.st == ddr_pm_pkg::ST_SR_RESTART) begin
            s_nxt.owed = 5'sh00;
        end else if (tick_ev && !ref_issued && s_r.owed < ddr_pm_pkg::OWED_MAX) begin
            s_nxt.owed = s_r.owed + 5'sh01;
        end else if (ref_issued && !tick_ev && s_r.owed > ddr_pm_pkg::OWED_MIN) begin
            s_nxt.owed = s_r.owed - 5'sh01;
        end
        if (ref_issued) begin
            s_nxt.ref_pend = 1'b0;
        end

        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            s_nxt.ack  = 1'b1;
            s_nxt.rdat = 32'h0000_0000;
            if (wb_adr_i == ddr_pm_pkg::ADR_CTRL) begin
                s_nxt.rdat[4:0] = {s_r.dram_rst, s_r.ref_pend, s_r.fast_pd,
                                   s_r.pd_req, s_r.sr_req};
                if (wb_we_i && wb_sel_i[0]) begin
                    s_nxt.sr_req   = wb_dat_i[ddr_pm_pkg::CTRL_SR_BIT];
                    s_nxt.pd_req   = wb_dat_i[ddr_pm_pkg::CTRL_PD_BIT];
                    s_nxt.fast_pd  = wb_dat_i[ddr_pm_pkg::CTRL_FASTPD_BIT];
                    s_nxt.dram_rst = wb_dat_i[ddr_pm_pkg::CTRL_DRST_BIT];
                    // a new request is not lost if a refresh clears it this cycle
                    if (wb_dat_i[ddr_pm_pkg::CTRL_REFNOW_BIT]) begin
                        s_nxt.ref_pend = 1'b1;
                    end
                end
            end else if (wb_adr_i == ddr_pm_pkg::ADR_STATUS) begin
                s_nxt.rdat[11:0] = {s_r.pins.ck_en, s_r.pins.cke, s_r.need_extra,
                                    s_r.owed, s_r.st};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r      <= '0;
            s_r.pins <= ddr_pm_pkg::PINS_RESET;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign ddr_o    = s_r.pins;

    // helper counters seen only by the checks below
    logic [9:0] since_pre;
    logic [9:0] since_ref;
    logic [9:0] cke_low;
    logic [9:0] cke_high;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_pre <= 10'h3FF;
            since_ref <= 10'h3FF;
            cke_low   <= 10'h000;
            cke_high  <= 10'h000;
        end else if (ce_i) begin
            since_pre <= (ddr_o.cmd == ddr_pm_pkg::CMD_PRE) ? 10'h001
                       : (since_pre == 10'h3FF) ? since_pre : since_pre + 10'h001;
            since_ref <= (ddr_o.cmd == ddr_pm_pkg::CMD_REF && ddr_o.cke) ? 10'h001
                       : (since_ref == 10'h3FF) ? since_ref : since_ref + 10'h001;
            cke_low   <= ddr_o.cke ? 10'h000
                       : (cke_low == 10'h3FF) ? cke_low : cke_low + 10'h001;
            cke_high  <= !ddr_o.cke ? 10'h000
                       : (cke_high == 10'h3FF) ? cke_high : cke_high + 10'h001;
        end
    end

    default clocking cb @(posedge clk_i iff ce_i); endclocking
    default disable iff (rst_i);

    sequence sre_seq;
        ddr_o.cmd == ddr_pm_pkg::CMD_REF && !ddr_o.cke;
    endsequence
    sequence srx_seq;
        s_r.st == ddr_pm_pkg::ST_SR_EXIT && $rose(ddr_o.cke);
    endsequence

    ref_decode_a: assert property (ddr_o.cmd == ddr_pm_pkg::CMD_REF && ddr_o.cke
        |-> $past(ddr_o.cke)) else $error("refresh without cke high");
    ref_precharged_a: assert property (ddr_o.cmd == ddr_pm_pkg::CMD_REF
        |-> since_pre >= 10'(TRP_CYC)) else $error("refresh before precharge time");
    refresh_gap_a: assert property (ddr_o.cke && ddr_o.cmd != ddr_pm_pkg::CMD_NOP
        && ddr_o.cmd != ddr_pm_pkg::CMD_DES |-> since_ref >= 10'(REFRESH_CYCLE_TIME_CYC))
        else $error("command inside refresh cycle time");
    owed_range_a: assert property (s_r.owed <= ddr_pm_pkg::OWED_MAX
        && s_r.owed >= ddr_pm_pkg::OWED_MIN) else $error("owed count out of range");
    sre_drained_a: assert property (sre_seq |-> $past(s_r.owed) <= 5'sh00
        && !$past(s_r.need_extra)) else $error("self-refresh with refresh owed");
    sr_cke_low_a: assert property (sre_seq |=> (!ddr_o.cke)[*2])
        else $error("cke rose right after self-refresh entry");
    cke_pulse_a: assert property ($rose(ddr_o.cke) |-> $past(cke_low) >= 10'(MIN_CKE_PULSE_CYC))
        else $error("cke low pulse too short");
    clk_stop_a: assert property (!ddr_o.ck_en |-> !ddr_o.cke
        && s_r.st == ddr_pm_pkg::ST_SR) else $error("clock stopped outside self-refresh");
    exit_nop_a: assert property (srx_seq |-> ddr_o.cmd == ddr_pm_pkg::CMD_NOP
        ##1 (ddr_o.cke && ddr_o.cmd == ddr_pm_pkg::CMD_NOP)[*8])
        else $error("exit period not nop with cke high");
    pd_blank_a: assert property (s_r.st == ddr_pm_pkg::ST_PD_ENT
        |-> !ddr_o.cke && ddr_o.cmd == ddr_pm_pkg::CMD_NOP)
        else $error("command during cke blanking");
    pd_limit_a: assert property (s_r.st == ddr_pm_pkg::ST_PD
        && s_r.owed == ddr_pm_pkg::OWED_MAX |=> s_r.st == ddr_pm_pkg::ST_PD_EXIT)
        else $error("power-down kept past refresh limit");
    pd_exit_wait_a: assert property ($fell(s_r.st == ddr_pm_pkg::ST_PD_EXIT) && !s_r.fast_pd
        |-> cke_high >= 10'(PDXS_CYC))
        else $error("slow exit left too soon");
endmodule

//--- sim/ddr_dev_model.sv
// behavioural memory device watching the controller's command pins
// assumes the pins are sampled on the rising edge of the shared clock
module ddr_dev_model #(
    parameter int TRP_CYC   = 1,
    parameter int REFRESH_CYCLE_TIME_CYC  = 4,
    parameter int MIN_CKE_PULSE_CYC  = 1,
    parameter int TCKSR_CYC = 1,
    parameter int TXS_CYC   = 16
) (
    input  wire ddr_pm_pkg::ddr_pins_type ddr_i,
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    output int                            refs_o,
    output int                            viol_o,
    output int                            max_gap_o,
    output logic                          in_sr_o,
    output logic                          in_pd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic nop, is_ref, cke_q, need_ref;
    int   pre_age, ref_age, sr_age, ck_age, quiet, gap, bad;
    assign nop    = ddr_i.cmd.cs_n || (ddr_i.cmd == ddr_pm_pkg::CMD_NOP);
    assign is_ref = (ddr_i.cmd == ddr_pm_pkg::CMD_REF);
    always @(posedge clk_i) begin
        bad = 0;
        if (rst_i) begin
            {cke_q, in_sr_o, in_pd_o, need_ref} <= 4'h8;
            {refs_o, viol_o, max_gap_o, gap, sr_age, ck_age} <= '0;
            pre_age <= 99;
            ref_age <= 99;
            quiet   <= 99;
        end else begin
            cke_q     <= ddr_i.cke;
            pre_age   <= pre_age + 1;
            ref_age   <= ref_age + 1;
            sr_age    <= sr_age + 1;
            quiet     <= quiet + 1;
            gap       <= gap + 1;
            ck_age    <= ddr_i.ck_en ? ck_age + 1 : 0;
            max_gap_o <= (gap > max_gap_o) ? gap : max_gap_o;
            if (!ddr_i.ck_en && !(in_sr_o && sr_age + 1 >= TCKSR_CYC)) bad++;
            if (ddr_i.termination_pin) bad++;
            if (in_sr_o || in_pd_o) begin
                // only cke counts while asleep, and reset as well in power-down
                if (ddr_i.cke) begin
                    if (!nop) bad++;
                    if (in_sr_o && (sr_age + 1 < MIN_CKE_PULSE_CYC || ck_age < TCKSR_CYC)) bad++;
                    quiet    <= in_sr_o ? 0 : 99;
                    need_ref <= need_ref | in_sr_o; // dll relocks from here
                    in_sr_o  <= 1'b0;
                    in_pd_o  <= 1'b0;
                end
                if (!ddr_i.reset_n) in_pd_o <= 1'b0;
            end else if (cke_q && !ddr_i.cke) begin
                if (is_ref) begin
                    // banks closed and no extra refresh still owed after an exit
                    if (pre_age + 1 < TRP_CYC || need_ref || ref_age + 1 < REFRESH_CYCLE_TIME_CYC) bad++;
                    in_sr_o <= 1'b1; // dll dropped for the stay
                    sr_age  <= 0;
                end else begin
                    if (!nop) bad++;
                    // banks never opened: precharge power-down, slow or fast
                    in_pd_o <= 1'b1;
                end
            end else if (!nop) begin
                if (ref_age + 1 < REFRESH_CYCLE_TIME_CYC || quiet + 1 < TXS_CYC) bad++;
                if (ddr_i.cmd == ddr_pm_pkg::CMD_PRE) pre_age <= 0;
                if (is_ref) begin
                    if (pre_age + 1 < TRP_CYC || !ddr_i.cke) bad++;
                    // row comes from the internal counter, banks idle after
                    refs_o   <= refs_o + 1;
                    ref_age  <= 0;
                    gap      <= 0;
                    need_ref <= 1'b0;
                end
            end
            viol_o <= viol_o + bad;
        end
    end
endmodule

//--- sim/ddr_pm_ctrl_bench.sv
// self-checking bench: wishbone master tasks, device model on the pins
// assumes one 20 MHz clock; refresh interval shortened to keep the run short
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module ddr_pm_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REFI_CYC = 40;
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     ce    = 1'b1;
    logic                     cyc   = 1'b0;
    logic                     stb   = 1'b0;
    logic                     we    = 1'b0;
    logic [3:0]               adr   = 4'h0;
    logic [3:0]               sel   = 4'hF;
    logic [31:0]              wdat  = 32'h0;
    logic [31:0]              rdat, q;
    logic                     ack, in_sr, in_pd;
    ddr_pm_pkg::ddr_pins_type pins;
    int                       refs, viol, max_gap, r0;
    int                       errors   = 0;
    int                       compares = 0;
    always #25 clk_i = ~clk_i;
    ddr_pm_ctrl #(.AVG_REFRESH_INTERVAL_NS(REFI_CYC * 50), .SELFREFRESH_EXIT_DLL_DELAY_CK(16)) u_ddr_pm_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ddr_o(pins));
    ddr_dev_model u_ddr_dev_model (
        .ddr_i(pins), .clk_i(clk_i), .rst_i(rst_i), .refs_o(refs), .viol_o(viol),
        .max_gap_o(max_gap), .in_sr_o(in_sr), .in_pd_o(in_pd));
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ack and data taken at the rising edge that sees ack; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] d);
        bus(1'b1, ddr_pm_pkg::ADR_CTRL, d, 4'hF);
    endtask
    task automatic st;
        bus(1'b0, ddr_pm_pkg::ADR_STATUS, 32'h0, 4'hF);
    endtask
    task automatic wait_flag(input logic sr, input logic v);
        int k;
        for (k = 0; k < 500 && (sr ? in_sr : in_pd) !== v; k++) @(negedge clk_i);
        if (k >= 500) errors++;
    endtask
    task automatic t_regs;
        st();
        `CHECK(q, 32'h00000C00)
        wr(32'h4);
        bus(1'b1, ddr_pm_pkg::ADR_CTRL, 32'h2, 4'h0);
        bus(1'b1, 4'h8, 32'h1F, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        `CHECK(q, 32'h0)
        bus(1'b0, ddr_pm_pkg::ADR_CTRL, 32'h0, 4'hF);
        `CHECK(q, 32'h4)
        wr(32'h0);
    endtask
    task automatic t_refresh;
        r0 = refs;
        wr(32'h8);
        repeat (20) @(negedge clk_i);
        `CHECK(refs > r0, 1'b1)
        bus(1'b0, ddr_pm_pkg::ADR_CTRL, 32'h0, 4'hF);
        `CHECK(q[3], 1'b0)
        r0 = refs;
        repeat (10 * REFI_CYC) @(negedge clk_i);
        `CHECK((refs - r0) inside {[9:11]}, 1'b1)
        `CHECK(viol, 0)
    endtask
    task automatic t_pd(input logic fast);
        wr({29'h0, fast, 2'b10});
        wait_flag(1'b0, 1'b1);
        `CHECK(in_pd, 1'b1)
        r0 = refs;
        repeat (9 * REFI_CYC + 20) @(negedge clk_i);
        `CHECK(refs > r0, 1'b1)
        `CHECK(max_gap <= 9 * REFI_CYC, 1'b1)
        wr(32'h0);
        wait_flag(1'b0, 1'b0);
        repeat (10) @(negedge clk_i);
        `CHECK(viol, 0)
    endtask
    // second pass re-enters soon after exit, so the extra refresh must come first
    task automatic t_sr;
        repeat (2) begin
            wr(32'h1);
            wait_flag(1'b1, 1'b1);
            `CHECK(in_sr, 1'b1)
            st();
            `CHECK(q[3:0], 4'h4)
            `CHECK(q[11:10], 2'b00)
            `CHECK($signed(q[8:4]) <= 0, 1'b1)
            repeat (50) @(negedge clk_i);
            wr(32'h0);
            wait_flag(1'b1, 1'b0);
            repeat (30) @(negedge clk_i);
            st();
            `CHECK(q[11:10], 2'b11)
            `CHECK(viol, 0)
        end
    endtask
    task automatic t_memreset;
        wr(32'h2);
        wait_flag(1'b0, 1'b1);
        wr(32'h12);
        repeat (3) @(negedge clk_i);
        `CHECK(pins.reset_n, 1'b0)
        `CHECK(in_pd, 1'b0)
        wr(32'h0);
        repeat (2) @(negedge clk_i);
        `CHECK(pins.reset_n, 1'b1)
    endtask
    // frozen in power-down past the owed limit: no exit, no refresh may follow
    task automatic t_ce;
        wr(32'h2);
        wait_flag(1'b0, 1'b1);
        @(posedge clk_i);
        ce <= 1'b0;
        r0 = refs;
        repeat (10 * REFI_CYC) @(negedge clk_i);
        `CHECK(refs, r0)
        `CHECK(pins.cke, 1'b0)
        @(posedge clk_i);
        ce <= 1'b1;
        wr(32'h0);
        wait_flag(1'b0, 1'b0);
        repeat (10) @(negedge clk_i);
        `CHECK(viol, 0)
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        $display("registers done");
        t_refresh();
        $display("refresh done");
        t_pd(1'b0);
        $display("slow power-down done");
        t_pd(1'b1);
        $display("fast power-down done");
        t_sr();
        $display("self-refresh done");
        t_memreset();
        $display("memory reset done");
        t_ce();
        $display("clock enable done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
endmodule
